/* core/ptc_pkg.sv */
// shared constants for the periodic tick counter
package ptc_pkg;
  // ==========================================
  // register map (word aligned)
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_TICK_COUNT = 12'h004;
  localparam logic [11:0] ADDR_COMPARE = 12'h008;

  // ==========================================
  // status/control field positions
  localparam int FLAG_BIT = 7;
  localparam int SRC_MSB = 6;
  localparam int SRC_LSB = 5;
  localparam int IE_BIT = 4;
  localparam int DIV_MSB = 3;
  localparam int DIV_LSB = 0;

  // ==========================================
  // reset values
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] DIV_OFF = 4'h0;

  // ==========================================
  // source select codes
  localparam logic [1:0] SRC_LOW_POWER = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  typedef enum logic [1:0] {PTC_SRC_LOW_POWER, PTC_SRC_EXT, PTC_SRC_INT} ptc_src_t;

  // ==========================================
  // prescaler divide ratios, index = divider select code
  localparam int PS_W = 18;
  localparam logic [PS_W-1:0] RATIO_BIN [16] = '{
    18'h00001, 18'h00008, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400,
    18'h00001, 18'h00002, 18'h00004, 18'h0000A, 18'h00010, 18'h00064, 18'h001F4, 18'h003E8};
  localparam logic [PS_W-1:0] RATIO_DEC [16] = '{
    18'h00001, 18'h00400, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000,
    18'h003E8, 18'h007D0, 18'h01388, 18'h02710, 18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40};
endpackage : ptc_pkg

/* core/ptc_presc_if.sv */
// carrier between the counter core and its prescaler
interface ptc_presc_if;
  logic src_edge;
  logic clear;
  logic freeze;
  logic [3:0] div_sel;
  logic src_bit0;
  logic tick;
  modport ctl (output src_edge, output clear, output freeze, output div_sel,
    output src_bit0, input tick);
  modport psc (input src_edge, input clear, input freeze, input div_sel,
    input src_bit0, output tick);
endinterface : ptc_presc_if

/* core/ptc_prescaler.sv */
// binary/decimal prescaler counting edges of the selected source
module ptc_prescaler (
  input wire logic clk_i,
  input wire logic rst_b_i,
  ptc_presc_if.psc pif
);
  logic [ptc_pkg::PS_W-1:0] ps_cnt_r;
  logic [ptc_pkg::PS_W-1:0] ratio_last;
  logic ps_run;
  logic ps_wrap;

  // ==========================================
  // ratio lookup: divider code and source bit 0 pick the table
  always_comb begin
    if (pif.src_bit0) begin
      ratio_last = ptc_pkg::RATIO_DEC[pif.div_sel] - 18'h00001;
    end else begin
      ratio_last = ptc_pkg::RATIO_BIN[pif.div_sel] - 18'h00001;
    end
  end

  // off at code zero, frozen while the debugger holds the core
  assign ps_run = (pif.div_sel != ptc_pkg::DIV_OFF) && !pif.freeze;
  assign ps_wrap = ps_run && pif.src_edge && (ps_cnt_r >= ratio_last);
  assign pif.tick = ps_wrap && !pif.clear;

  // edge counter; >= guards against a ratio lowered mid-count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ps_cnt_r <= '0;
    end else if (pif.clear) begin
      ps_cnt_r <= '0;
    end else if (ps_run && pif.src_edge) begin
      ps_cnt_r <= ps_wrap ? '0 : ps_cnt_r + 18'h00001;
    end
  end

  a_presc_off_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (pif.div_sel == ptc_pkg::DIV_OFF) |-> (!pif.tick ##1 $stable(ps_cnt_r)))
    else $error("prescaler moved while off");
  a_presc_frozen: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pif.freeze |-> !pif.tick)
    else $error("prescaler ticked while frozen");
endmodule : ptc_prescaler

/* core/ptc_tick_counter.sv */
// periodic tick counter: apb registers, source select, 8-bit compare counter
// Operation
// - 8-bit up-counter, 8-bit compare, source selector, binary/decimal prescaler
// - compare register is read/write and takes any value 0x00 to 0xFF
// - counter steps once per prescaler tick, returns to zero after compare value
// - match flag sets on the step from compare value back to zero
// - compare of zero sets the flag on every prescaler tick
// - any compare write clears prescaler and counter
// - reset: counter zero and stopped, compare zero, prescaler off, low-power source
// - prescaler off while divider select is zero, runs once non-zero
// - source code 00 low-power, 01 external, 1x internal reference
// - writing a different source code clears prescaler and counter
// - writing a different divider code clears prescaler and counter
// - divide ratio picked by divider code together with source bit 0
// - interrupt request asserted while flag and enable are both set
// - writing one to the flag bit clears flag and request, except when a wrap sets the flag in the same cycle
// - ratio tables for source bit 0 low and high
// - counter register read-only; writing zero to flag bit does nothing
// - debug halt freezes counting; resumes from held value
//
// The placing of the registers and the APB slave port were left to the implementer.
module ptc_tick_counter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [ptc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic low_power_osc_clock_i,
  input wire logic external_ref_clock_i,
  input wire logic internal_ref_clock_i,
  input wire logic debug_halt_i,
  output logic irq_o
);
  // ==========================================
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_b;

  // assert at once, release two edges later to keep recovery clean
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  // ==========================================
  // source clock sampling
  logic [2:0] src_meta_r;
  logic [2:0] src_sync_r;
  logic [2:0] src_prev_r;
  logic [2:0] src_raw;
  logic [2:0] src_rise;

  assign src_raw = {internal_ref_clock_i, external_ref_clock_i, low_power_osc_clock_i};

  // two flops per source, then an edge stage; sources must be well below ref_clk/2
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_src_sync
      always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
          src_meta_r[gi] <= 1'b0;
          src_sync_r[gi] <= 1'b0;
          src_prev_r[gi] <= 1'b0;
        end else begin
          src_meta_r[gi] <= src_raw[gi];
          src_sync_r[gi] <= src_meta_r[gi];
          src_prev_r[gi] <= src_sync_r[gi];
        end
      end
      assign src_rise[gi] = src_sync_r[gi] && !src_prev_r[gi];
    end
  endgenerate

  // ==========================================
  // configuration and state registers
  logic [1:0] src_sel_r;
  logic [3:0] div_sel_r;
  logic irq_en_r;
  logic [7:0] cmp_r;
  logic [7:0] cnt_r;
  logic flag_r;
  logic [31:0] prdata_r;
  logic slverr_r;

  // ==========================================
  // apb decode
  logic apb_setup;
  logic apb_access;
  logic wr_en;
  logic sc_wr;
  logic cmp_wr;
  logic src_chg;
  logic div_chg;
  logic clear_all;
  logic [1:0] src_nxt;
  logic [3:0] div_nxt;

  // one word per register, only lane 0 carries data
  function automatic logic addr_hit(input logic [ptc_pkg::ADDR_W-1:0] a);
    return (a == ptc_pkg::ADDR_STATUS_CONTROL) || (a == ptc_pkg::ADDR_TICK_COUNT)
      || (a == ptc_pkg::ADDR_COMPARE);
  endfunction : addr_hit

  assign apb_setup = psel_i && !penable_i;
  assign apb_access = psel_i && penable_i;
  assign pready_o = 1'b1; // data was staged during setup, so no wait states
  assign wr_en = apb_access && pwrite_i && pstrb_i[0] && addr_hit(paddr_i);
  assign sc_wr = wr_en && (paddr_i == ptc_pkg::ADDR_STATUS_CONTROL);
  assign cmp_wr = wr_en && (paddr_i == ptc_pkg::ADDR_COMPARE);
  assign src_nxt = pwdata_i[ptc_pkg::SRC_MSB:ptc_pkg::SRC_LSB];
  assign div_nxt = pwdata_i[ptc_pkg::DIV_MSB:ptc_pkg::DIV_LSB];
  assign src_chg = sc_wr && (src_nxt != src_sel_r);
  assign div_chg = sc_wr && (div_nxt != div_sel_r);
  assign clear_all = cmp_wr || src_chg || div_chg;

  // configuration fields, all cleared by reset
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      src_sel_r <= ptc_pkg::SRC_RST;
      div_sel_r <= ptc_pkg::DIV_RST;
      irq_en_r <= 1'b0;
    end else if (sc_wr) begin
      src_sel_r <= src_nxt;
      div_sel_r <= div_nxt;
      irq_en_r <= pwdata_i[ptc_pkg::IE_BIT];
    end
  end

  // compare register, full 8-bit range
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cmp_r <= ptc_pkg::CMP_RST;
    end else if (cmp_wr) begin
      cmp_r <= pwdata_i[7:0];
    end
  end

  // ==========================================
  // source selection
  ptc_pkg::ptc_src_t src_kind;
  logic src_edge;

  // codes 10 and 11 both land on the internal reference
  always_comb begin
    if (src_sel_r == ptc_pkg::SRC_LOW_POWER) begin
      src_kind = ptc_pkg::PTC_SRC_LOW_POWER;
    end else if (src_sel_r == ptc_pkg::SRC_EXT) begin
      src_kind = ptc_pkg::PTC_SRC_EXT;
    end else begin
      src_kind = ptc_pkg::PTC_SRC_INT;
    end
  end

  always_comb begin
    case (src_kind)
      ptc_pkg::PTC_SRC_LOW_POWER: src_edge = src_rise[0];
      ptc_pkg::PTC_SRC_EXT: src_edge = src_rise[1];
      default: src_edge = src_rise[2];
    endcase
  end

  // ==========================================
  // prescaler
  ptc_presc_if pif ();

  assign pif.src_edge = src_edge;
  assign pif.clear = clear_all;
  assign pif.freeze = debug_halt_i;
  assign pif.div_sel = div_sel_r;
  assign pif.src_bit0 = src_sel_r[0];

  ptc_prescaler u_presc (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b),
    .pif(pif)
  );

  // ==========================================
  // main counter and match flag
  logic at_cmp;
  logic wrap;

  assign at_cmp = (cnt_r == cmp_r);
  assign wrap = pif.tick && at_cmp;

  // holds between ticks; clears win over a coincident tick
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= ptc_pkg::CNT_RST;
    end else if (clear_all) begin
      cnt_r <= ptc_pkg::CNT_RST;
    end else if (pif.tick) begin
      cnt_r <= at_cmp ? ptc_pkg::CNT_RST : cnt_r + 8'h01;
    end
  end

  // a wrap in the clearing cycle wins, so no event is lost
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else if (wrap) begin
      flag_r <= 1'b1;
    end else if (sc_wr && pwdata_i[ptc_pkg::FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  assign irq_o = flag_r && irq_en_r;

  // ==========================================
  // read path, staged in the setup phase
  always_ff @(posedge ref_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else if (apb_setup) begin
      slverr_r <= !addr_hit(paddr_i);
      if (paddr_i == ptc_pkg::ADDR_STATUS_CONTROL) begin
        prdata_r <= {24'h000000, flag_r, src_sel_r, irq_en_r, div_sel_r};
      end else if (paddr_i == ptc_pkg::ADDR_TICK_COUNT) begin
        prdata_r <= {24'h000000, cnt_r};
      end else if (paddr_i == ptc_pkg::ADDR_COMPARE) begin
        prdata_r <= {24'h000000, cmp_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pslverr_o = slverr_r && apb_access;

  // ==========================================
  // checks
  a_wrap_to_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (pif.tick && at_cmp && !clear_all) |=> (cnt_r == 8'h00))
    else $error("counter did not return to zero at compare");
  a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (pif.tick && !at_cmp && !clear_all) |=> (cnt_r == $past(cnt_r) + 8'h01))
    else $error("counter did not advance by one");
  a_flag_on_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (pif.tick && at_cmp && !clear_all) |=> flag_r)
    else $error("flag missing after wrap");
  a_flag_no_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (!flag_r && !pif.tick) |=> !flag_r)
    else $error("flag set without a wrap");
  a_zero_cmp_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (cmp_r == 8'h00 && pif.tick && !clear_all) |=> (flag_r && cnt_r == 8'h00))
    else $error("zero compare did not flag every tick");
  a_cmp_wr_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    cmp_wr |=> (cnt_r == 8'h00 && cmp_r == $past(pwdata_i[7:0]))
  ) else $error("compare write did not clear the counter");
  a_src_chg_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    src_chg |=> (cnt_r == 8'h00))
    else $error("source change did not clear the counter");
  a_div_chg_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    div_chg |=> (cnt_r == 8'h00))
    else $error("divider change did not clear the counter");
  a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (wrap && irq_en_r && !sc_wr) |=> irq_o)
    else $error("interrupt not raised on flagged wrap");
  a_flag_w1c: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (sc_wr && pwdata_i[ptc_pkg::FLAG_BIT] && !wrap) |=> (!flag_r && !irq_o))
    else $error("write one did not clear flag");
  a_flag_w0_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (flag_r && !(sc_wr && pwdata_i[ptc_pkg::FLAG_BIT])) |=> flag_r)
    else $error("flag lost without a write one");
  a_hold_no_tick: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (!pif.tick && !clear_all) |=> $stable(cnt_r))
    else $error("counter moved without a tick");
  a_halt_freeze: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (debug_halt_i && !clear_all) [*2] |-> $stable(cnt_r))
    else $error("counter moved during debug halt");
  a_div_off_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    (div_sel_r == ptc_pkg::DIV_OFF && !clear_all) |=> $stable(cnt_r))
    else $error("counter moved with the prescaler off");
  a_cmp_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b)
    !cmp_wr |=> $stable(cmp_r))
    else $error("compare value changed without a write");

  // ==========================================
  // scenario covers
  c_wrap_seen: cover property (@(posedge ref_clk_i) disable iff (!rst_b)
    wrap && cmp_r != 8'h00);
  c_zero_cmp: cover property (@(posedge ref_clk_i) disable iff (!rst_b)
    wrap && cmp_r == 8'h00);
  c_irq_raised: cover property (@(posedge ref_clk_i) disable iff (!rst_b)
    !irq_o ##1 irq_o);
  c_src_change: cover property (@(posedge ref_clk_i) disable iff (!rst_b)
    src_chg && cnt_r != 8'h00);
  c_halt_resume: cover property (@(posedge ref_clk_i) disable iff (!rst_b)
    debug_halt_i ##1 !debug_halt_i);
endmodule : ptc_tick_counter

/* tb/ptc_tick_counter_tb.sv */
// self-checking testbench for the periodic tick counter
module ptc_tick_counter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, debug_halt_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0] pstrb_i;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, irq_o;
  logic [4:0] src_cnt;
  int num_errors;
  int samples_checked;
  logic [31:0] rd_val, c1;
  logic err;

  ptc_tick_counter dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .low_power_osc_clock_i(src_cnt[2]), .external_ref_clock_i(src_cnt[3]),
    .internal_ref_clock_i(src_cnt[4]), .debug_halt_i(debug_halt_i), .irq_o(irq_o));

  // ==========================================
  // clock and source clocks
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // sources kept slow: each phase spans at least 4 ref cycles for the synchroniser
  always @(posedge ref_clk_i) begin
    src_cnt <= src_cnt + 5'h01;
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1) @(posedge ref_clk_i);
    rd_val = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle

  task automatic stop_test();
    $display("checks made %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================
  // watchdog: tests need about 1400 cycles
  initial begin
    idle(20000);
    num_errors++;
    stop_test();
  end

  // ==========================================
  // main sequence
  initial begin
    src_cnt = 5'h00;
    rst_b_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    pstrb_i = 4'hF;
    debug_halt_i = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    idle(5);
    rst_b_i <= 1'b1;
    idle(3);
    // reset state and register access
    rd(ptc_pkg::ADDR_STATUS_CONTROL);
    chk(rd_val, 32'h00000000);
    rd(ptc_pkg::ADDR_COMPARE);
    chk(rd_val, 32'h00000000);
    wr(ptc_pkg::ADDR_COMPARE, 8'hFF);
    rd(ptc_pkg::ADDR_COMPARE);
    chk(rd_val, 32'h000000FF);
    wr(ptc_pkg::ADDR_TICK_COUNT, 8'hAA);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk(rd_val, 32'h00000000);
    idle(100);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk(rd_val, 32'h00000000);
    rd(12'h00C);
    chk({rd_val[30:0], err}, 32'h00000001);
    $display("test registers done");
    // wrap at compare 3, flag and interrupt
    wr(ptc_pkg::ADDR_COMPARE, 8'h03);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h18);
    idle(100);
    rd(ptc_pkg::ADDR_STATUS_CONTROL);
    chk(rd_val, 32'h00000098);
    chk({31'h0, irq_o}, 32'h1);
    c1 = 32'h0;
    for (int i = 0; i < 14; i++) begin
      rd(ptc_pkg::ADDR_TICK_COUNT);
      if (rd_val > c1) c1 = rd_val;
    end
    chk(c1, 32'h00000003);
    wr(ptc_pkg::ADDR_COMPARE, 8'hFF);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h18);
    rd(ptc_pkg::ADDR_STATUS_CONTROL);
    chk(rd_val, 32'h00000098);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h98);
    rd(ptc_pkg::ADDR_STATUS_CONTROL);
    chk(rd_val, 32'h00000018);
    chk({31'h0, irq_o}, 32'h0);
    $display("test wrap done");
    // compare of zero flags every tick
    wr(ptc_pkg::ADDR_COMPARE, 8'h00);
    idle(20);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h98);
    idle(20);
    rd(ptc_pkg::ADDR_STATUS_CONTROL);
    chk(rd_val, 32'h00000098);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk(rd_val, 32'h00000000);
    $display("test compare zero done");
    // clearing by compare, source and divider writes
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h88);
    idle(20);
    chk({31'h0, irq_o}, 32'h0);
    wr(ptc_pkg::ADDR_COMPARE, 8'hFF);
    idle(100);
    wr(ptc_pkg::ADDR_COMPARE, 8'hFF);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val <= 32'h1}, 32'h1);
    idle(60);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    c1 = rd_val;
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h08);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val >= c1 && c1 >= 32'h5}, 32'h1);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h28);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val <= 32'h1}, 32'h1);
    idle(200);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val <= 32'h1}, 32'h1);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h08);
    idle(60);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h01);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val <= 32'h1}, 32'h1);
    // ratio 8 from an 8-cycle source: one tick per 64 cycles
    idle(290);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val >= 32'h3 && rd_val <= 32'h5}, 32'h1);
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h00);
    idle(100);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk(rd_val, 32'h00000000);
    $display("test clearing done");
    // debug halt freezes the count
    wr(ptc_pkg::ADDR_STATUS_CONTROL, 8'h08);
    idle(30);
    debug_halt_i <= 1'b1;
    idle(5);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    c1 = rd_val;
    idle(60);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk(rd_val, c1);
    debug_halt_i <= 1'b0;
    idle(40);
    rd(ptc_pkg::ADDR_TICK_COUNT);
    chk({31'h0, rd_val > c1}, 32'h1);
    $display("test halt done");
    stop_test();
  end
endmodule : ptc_tick_counter_tb
